// ---- common/ltm_regs.svh ----
// register map, reset values, field positions, fault codes and timing of the trip monitor
`ifndef LTM_REGS_SVH
`define LTM_REGS_SVH
`define LTM_IDX_CTRL 5'h00
`define LTM_IDX_IMB_LVL 5'h01
`define LTM_IDX_IMB_DLY 5'h02
`define LTM_IDX_RES_LVL 5'h03
`define LTM_IDX_ZS_LVL 5'h04
`define LTM_IDX_GND_DLY 5'h05
`define LTM_IDX_OV_LVL 5'h06
`define LTM_IDX_UV_LVL 5'h07
`define LTM_IDX_VOLT_DLY 5'h08
`define LTM_IDX_PLOSS_DLY 5'h09
`define LTM_IDX_OF_LVL 5'h0A
`define LTM_IDX_UF_LVL 5'h0B
`define LTM_IDX_FREQ_DLY 5'h0C
`define LTM_IDX_LEAD_LVL 5'h0D
`define LTM_IDX_LAG_LVL 5'h0E
`define LTM_IDX_PF_DLY 5'h0F
`define LTM_IDX_RATED_V 5'h10
`define LTM_IDX_FLA 5'h11
`define LTM_IDX_STATUS 5'h12
`define LTM_RST_IMB_LVL 16'h000F
`define LTM_RST_IMB_DLY 16'h0064
`define LTM_RST_GND_DLY 16'h001E
`define LTM_RST_VOLT_DLY 16'h0001
`define LTM_RST_PLOSS_DLY 16'h0002
`define LTM_RST_OF_LVL 16'h0048
`define LTM_RST_UF_LVL 16'h0017
`define LTM_RST_FREQ_DLY 16'h0001
`define LTM_RST_PF_DLY 16'h0064
`define LTM_RST_RATED_V 16'h01E0
`define LTM_RST_FLA 16'h0064
`define LTM_CTRL_CLR_BIT 0
`define LTM_PF_EN_BIT 8
`define LTM_ST_TRIP_BIT 8
`define LTM_ST_VALARM_BIT 9
`define LTM_ST_GRELAY_BIT 10
`define LTM_ST_COND_LSB 16
`define LTM_CODE_IMB 8'h25
`define LTM_CODE_GND 8'h26
`define LTM_CODE_PLOSS 8'h1B
`define LTM_CODE_OF 8'h0D
`define LTM_CODE_UF 8'h0C
`define LTM_CODE_LEAD 8'h23
`define LTM_CODE_LAG 8'h24
`define LTM_STEP_MS 100
`define LTM_CLK_KHZ 100000
`endif

// ---- common/ltm_pkg.sv ----
// types shared by the trip monitor
`default_nettype none
package ltm_pkg;
  typedef struct packed {
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_c;
    logic signed [15:0] inst_a;
    logic signed [15:0] inst_b;
    logic signed [15:0] inst_c;
    logic [15:0] volt_a;
    logic [15:0] volt_b;
    logic [15:0] volt_c;
    logic [7:0] freq_hz;
    logic [15:0] zs_gnd;
    logic signed [7:0] pf;
    logic phase_ok;
    logic running;
    logic sample;
  } ltm_meas_t;
  typedef enum logic {LTM_ST_RUN, LTM_ST_TRIP} ltm_state_t;
endpackage
`default_nettype wire

// ---- design/ltm_trip_monitor.sv ----
// line protection trip monitor with AHB-Lite settings registers
//
// Implementation choices: register access over AHB-Lite and the address map.
`include "ltm_regs.svh"
`default_nettype none
module ltm_trip_monitor
  import ltm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LTM_STEP_MS * `LTM_CLK_KHZ,
  parameter logic [7:0] VOLT_FAULT_CODE = 8'h0A,
  parameter int NT = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ltm_meas_t meas,
  output logic trip,
  output logic [7:0] fault_code,
  output logic volt_alarm,
  output logic gnd_relay,
  output logic [7:0] alarm
);
  localparam int NREG = 18;
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  logic [15:0] set_q [1:NREG-1];
  logic wr_q;
  logic [4:0] widx_q;
  logic [31:0] hrdata_q;
  logic trip_q;
  logic [7:0] code_q;
  logic volt_alarm_q;
  logic gnd_relay_q;
  logic [7:0] alarm_q;
  ltm_state_t state_q;
  logic [7:0] cond_q;
  logic [7:0] raw_w;
  logic [7:0] en_w;
  logic [7:0] cond_w;
  logic [7:0] exp_w;
  logic gnd_raw_w;
  logic clr_w;
  logic [9:0] dly_w [NT];
  logic [23:0] sub_q [NT];
  logic [9:0] ten_q [NT];

  function automatic logic [15:0] rst_val(input int i);
    case (i)
      1: rst_val = `LTM_RST_IMB_LVL;
      2: rst_val = `LTM_RST_IMB_DLY;
      5: rst_val = `LTM_RST_GND_DLY;
      8: rst_val = `LTM_RST_VOLT_DLY;
      9: rst_val = `LTM_RST_PLOSS_DLY;
      10: rst_val = `LTM_RST_OF_LVL;
      11: rst_val = `LTM_RST_UF_LVL;
      12: rst_val = `LTM_RST_FREQ_DLY;
      15: rst_val = `LTM_RST_PF_DLY;
      16: rst_val = `LTM_RST_RATED_V;
      17: rst_val = `LTM_RST_FLA;
      default: rst_val = 16'h0000;
    endcase
  endfunction

  // a zero delay would trip on the first cycle, so it is held to one step
  function automatic logic [9:0] dly(input logic [15:0] s);
    dly = (s[9:0] == 10'h000) ? 10'h001 : s[9:0];
  endfunction

  function automatic logic [17:0] adiff(input logic [17:0] a, input logic [17:0] b);
    adiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic vhi(input logic [15:0] v, input logic [15:0] l, input logic [15:0] r);
    vhi = ({24'h0, v} * 40'd100) > (({24'h0, l} + 40'd100) * {24'h0, r});
  endfunction

  function automatic logic vlo(input logic [15:0] v, input logic [15:0] l, input logic [15:0] r);
    vlo = ({24'h0, v} * 40'd100) < ((40'd100 - {24'h0, l}) * {24'h0, r});
  endfunction

  function automatic logic [7:0] code_of(input int i);
    case (i)
      0: code_of = `LTM_CODE_IMB;
      1: code_of = `LTM_CODE_GND;
      2: code_of = VOLT_FAULT_CODE;
      3: code_of = `LTM_CODE_PLOSS;
      4: code_of = `LTM_CODE_OF;
      5: code_of = `LTM_CODE_UF;
      6: code_of = `LTM_CODE_LEAD;
      default: code_of = `LTM_CODE_LAG;
    endcase
  endfunction

  function automatic logic [7:0] first_code(input logic [7:0] e);
    first_code = 8'h00;
    for (int i = NT - 1; i >= 0; i--) begin
      if (e[i]) begin
        first_code = code_of(i);
      end
    end
  endfunction

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // bus slave: zero wait state, always OKAY
  logic acc_w;
  logic [4:0] ridx_w;
  logic rmap_w;
  logic [31:0] rval_w;
  assign acc_w = hsel && htrans[1] && hready;
  assign ridx_w = haddr[6:2];
  assign rmap_w = (haddr[31:7] == 25'h0) && (ridx_w <= `LTM_IDX_STATUS);
  assign clr_w = wr_q && (widx_q == `LTM_IDX_CTRL) && hwdata[`LTM_CTRL_CLR_BIT];

  always_comb begin
    rval_w = 32'h0000_0000;
    if (!rmap_w || ridx_w == `LTM_IDX_CTRL) begin
      rval_w = 32'h0000_0000;
    end else if (ridx_w == `LTM_IDX_STATUS) begin
      rval_w[7:0] = code_q;
      rval_w[`LTM_ST_TRIP_BIT] = trip_q;
      rval_w[`LTM_ST_VALARM_BIT] = volt_alarm_q;
      rval_w[`LTM_ST_GRELAY_BIT] = gnd_relay_q;
      rval_w[`LTM_ST_COND_LSB +: 8] = alarm_q;
    end else if (wr_q && widx_q == ridx_w) begin
      // a write still in its data phase is forwarded so back-to-back read sees it
      rval_w[15:0] = hwdata[15:0];
    end else begin
      rval_w[15:0] = set_q[ridx_w];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      widx_q <= 5'h00;
    end else begin
      wr_q <= acc_w && hwrite && rmap_w;
      widx_q <= ridx_w;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc_w && !hwrite) begin
        hrdata_q <= rval_w;
      end
    end
  end
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 1; i < NREG; i++) begin
        set_q[i] <= rst_val(i);
      end
    end else if (wr_q && widx_q != `LTM_IDX_CTRL && widx_q != `LTM_IDX_STATUS) begin
      set_q[widx_q] <= hwdata[15:0];
    end
  end

  // protection conditions from the latest per-cycle sample
  logic [17:0] sum3, fla3, den3, dmax, d_a, d_b, d_c;
  logic signed [17:0] rsum;
  logic [17:0] rabs;
  logic vh, vl;
  always_comb begin
    sum3 = {2'b00, meas.cur_a} + {2'b00, meas.cur_b} + {2'b00, meas.cur_c};
    fla3 = 18'({2'b00, set_q[`LTM_IDX_FLA]} * 18'd3);
    d_a = adiff(18'({2'b00, meas.cur_a} * 18'd3), sum3);
    d_b = adiff(18'({2'b00, meas.cur_b} * 18'd3), sum3);
    d_c = adiff(18'({2'b00, meas.cur_c} * 18'd3), sum3);
    dmax = (d_a > d_b) ? d_a : d_b;
    dmax = (d_c > dmax) ? d_c : dmax;
    den3 = (sum3 <= fla3) ? fla3 : sum3;
    raw_w = 8'h00;
    raw_w[0] = ({22'h0, dmax} * 40'd100) > ({24'h0, set_q[`LTM_IDX_IMB_LVL]} * {22'h0, den3});
    rsum = 18'(meas.inst_a) + 18'(meas.inst_b) + 18'(meas.inst_c);
    rabs = rsum[17] ? 18'(-rsum) : 18'(rsum);
    gnd_raw_w = ((set_q[`LTM_IDX_RES_LVL] != 16'h0)
                 && ({22'h0, rabs} * 40'd100
                     >= {24'h0, set_q[`LTM_IDX_RES_LVL]} * {24'h0, set_q[`LTM_IDX_FLA]}))
                || ((set_q[`LTM_IDX_ZS_LVL] != 16'h0) && (meas.zs_gnd >= set_q[`LTM_IDX_ZS_LVL]));
    raw_w[1] = gnd_raw_w;
    vh = vhi(meas.volt_a, set_q[`LTM_IDX_OV_LVL], set_q[`LTM_IDX_RATED_V])
         || vhi(meas.volt_b, set_q[`LTM_IDX_OV_LVL], set_q[`LTM_IDX_RATED_V])
         || vhi(meas.volt_c, set_q[`LTM_IDX_OV_LVL], set_q[`LTM_IDX_RATED_V]);
    vl = vlo(meas.volt_a, set_q[`LTM_IDX_UV_LVL], set_q[`LTM_IDX_RATED_V])
         || vlo(meas.volt_b, set_q[`LTM_IDX_UV_LVL], set_q[`LTM_IDX_RATED_V])
         || vlo(meas.volt_c, set_q[`LTM_IDX_UV_LVL], set_q[`LTM_IDX_RATED_V]);
    raw_w[2] = meas.running && ((set_q[`LTM_IDX_OV_LVL] != 16'h0 && vh)
                                || (set_q[`LTM_IDX_UV_LVL] != 16'h0 && vl));
    raw_w[3] = meas.running && !meas.phase_ok;
    raw_w[4] = meas.freq_hz > set_q[`LTM_IDX_OF_LVL][7:0];
    raw_w[5] = meas.freq_hz < set_q[`LTM_IDX_UF_LVL][7:0];
    raw_w[6] = meas.pf > $signed(set_q[`LTM_IDX_LEAD_LVL][7:0]);
    raw_w[7] = meas.pf < $signed(set_q[`LTM_IDX_LAG_LVL][7:0]);
  end

  // off levels gate the live condition so the timer clears at once
  always_comb begin
    en_w = 8'hFF;
    en_w[0] = set_q[`LTM_IDX_IMB_LVL] != 16'h0;
    en_w[1] = ((set_q[`LTM_IDX_RES_LVL] | set_q[`LTM_IDX_ZS_LVL]) != 16'h0) && !trip_q;
    en_w[2] = (set_q[`LTM_IDX_OV_LVL] | set_q[`LTM_IDX_UV_LVL]) != 16'h0;
    en_w[6] = set_q[`LTM_IDX_LEAD_LVL][`LTM_PF_EN_BIT];
    en_w[7] = set_q[`LTM_IDX_LAG_LVL][`LTM_PF_EN_BIT];
  end
  assign cond_w = cond_q & en_w;

  assign dly_w[0] = dly(set_q[`LTM_IDX_IMB_DLY]);
  assign dly_w[1] = dly(set_q[`LTM_IDX_GND_DLY]);
  assign dly_w[2] = dly(set_q[`LTM_IDX_VOLT_DLY]);
  assign dly_w[3] = dly(set_q[`LTM_IDX_PLOSS_DLY]);
  assign dly_w[4] = dly(set_q[`LTM_IDX_FREQ_DLY]);
  assign dly_w[5] = dly(set_q[`LTM_IDX_FREQ_DLY]);
  assign dly_w[6] = dly(set_q[`LTM_IDX_PF_DLY]);
  assign dly_w[7] = dly(set_q[`LTM_IDX_PF_DLY]);

  // conditions hold between samples; the front end strobes once per line cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_q <= 8'h00;
    end else if (meas.sample) begin
      cond_q <= raw_w;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_tmr
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sub_q[g] <= 24'h0;
          ten_q[g] <= 10'h0;
        end else if (!cond_w[g]) begin
          sub_q[g] <= 24'h0;
          ten_q[g] <= 10'h0;
        end else if (ten_q[g] != dly_w[g]) begin
          if (sub_q[g] == TICK_LAST) begin
            sub_q[g] <= 24'h0;
            ten_q[g] <= ten_q[g] + 10'h1;
          end else begin
            sub_q[g] <= sub_q[g] + 24'h1;
          end
        end
      end
      assign exp_w[g] = cond_w[g] && (ten_q[g] == dly_w[g]);
    end
  endgenerate

  // first fault latches; a clear in the same cycle as an expiry loses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= LTM_ST_RUN;
      trip_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      case (state_q)
        LTM_ST_RUN: begin
          if (exp_w != 8'h00) begin
            state_q <= LTM_ST_TRIP;
            trip_q <= 1'b1;
            code_q <= first_code(exp_w);
          end
        end
        LTM_ST_TRIP: begin
          if (clr_w && exp_w == 8'h00) begin
            state_q <= LTM_ST_RUN;
            trip_q <= 1'b0;
            code_q <= 8'h00;
          end
        end
        default: begin
          state_q <= LTM_ST_RUN;
          trip_q <= 1'b0;
          code_q <= 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      volt_alarm_q <= 1'b0;
      gnd_relay_q <= 1'b0;
      alarm_q <= 8'h00;
    end else begin
      volt_alarm_q <= cond_w[2];
      gnd_relay_q <= cond_q[1] && (en_w[1] || trip_q);
      alarm_q <= cond_w;
    end
  end

  assign trip = trip_q;
  assign fault_code = code_q;
  assign volt_alarm = volt_alarm_q;
  assign gnd_relay = gnd_relay_q;
  assign alarm = alarm_q;

  sequence s_of_due;
    exp_w[4] && exp_w[3:0] == 4'h0 && state_q == LTM_ST_RUN;
  endsequence
  sequence s_of_trip;
    trip_q && code_q == `LTM_CODE_OF;
  endsequence

  property p_off_clear;
    set_q[`LTM_IDX_IMB_LVL] == 16'h0 |=> ten_q[0] == 10'h0 && alarm_q[0] == 1'b0;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("off imbalance timer not clear");

  property p_restart;
    !cond_w[3] |=> ten_q[3] == 10'h0 && sub_q[3] == 24'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("phase loss timer not restarted");

  property p_imb_cause;
    $rose(trip_q) && code_q == `LTM_CODE_IMB |-> $past(exp_w[0]);
  endproperty
  a_imb_cause: assert property (p_imb_cause) else $error("imbalance code without expiry");

  property p_gnd_block;
    trip_q && code_q != `LTM_CODE_GND |=> ten_q[1] == 10'h0;
  endproperty
  a_gnd_block: assert property (p_gnd_block) else $error("ground timed during other fault");

  property p_gnd_relay;
    meas.sample && gnd_raw_w |=> ##1 gnd_relay_q;
  endproperty
  a_gnd_relay: assert property (p_gnd_relay) else $error("ground relay not energised");

  property p_volt_run;
    meas.sample && !meas.running |=> !cond_q[2] ##1 !volt_alarm_q;
  endproperty
  a_volt_run: assert property (p_volt_run) else $error("voltage evaluated while stopped");

  property p_volt_alarm_first;
    $rose(trip_q) && code_q == VOLT_FAULT_CODE |-> $past(volt_alarm_q);
  endproperty
  a_volt_alarm_first: assert property (p_volt_alarm_first) else $error("voltage fault without alarm");

  property p_of_trip;
    s_of_due |=> s_of_trip;
  endproperty
  a_of_trip: assert property (p_of_trip) else $error("over frequency code not declared");

  property p_gnd_step;
    cond_w[1] && ten_q[1] != dly_w[1] && sub_q[1] == TICK_LAST |=> ten_q[1] == $past(ten_q[1]) + 10'h1;
  endproperty
  a_gnd_step: assert property (p_gnd_step) else $error("ground delay step missed");

  property p_gnd_code;
    $rose(trip_q) && $past(exp_w) == 8'h02 |-> code_q == `LTM_CODE_GND;
  endproperty
  a_gnd_code: assert property (p_gnd_code) else $error("ground fault code wrong");
endmodule
`default_nettype wire

// ---- dv/ltm_meas_model.sv ----
// measurement front end model: refreshes the values and pulses sample every fourth cycle
`default_nettype none
module ltm_meas_model
  import ltm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire ltm_meas_t want,
  output var ltm_meas_t meas
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  // one pulse per line cycle, the values behind it always current
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 2'h0;
      meas <= '0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      meas <= want;
      meas.sample <= (cnt_q == 2'h3);
    end
  end
endmodule
`default_nettype wire

// ---- dv/ltm_trip_monitor_tb.sv ----
// self-checking bench of the trip monitor
`include "ltm_regs.svh"
`default_nettype none
module ltm_trip_monitor_tb
  import ltm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VCODE = 8'h0A;
  typedef struct packed {
    logic [3:0] kind;
    logic [4:0] lidx;
    logic [15:0] lval;
    logic [4:0] didx;
    logic [7:0] code;
    logic [2:0] abit;
  } ltm_row_t;
  localparam ltm_row_t ROWS [10] = '{
    '{4'h0, `LTM_IDX_IMB_LVL, 16'h000F, `LTM_IDX_IMB_DLY, `LTM_CODE_IMB, 3'h0},
    '{4'h1, `LTM_IDX_RES_LVL, 16'h000A, `LTM_IDX_GND_DLY, `LTM_CODE_GND, 3'h1},
    '{4'h2, `LTM_IDX_ZS_LVL, 16'h000A, `LTM_IDX_GND_DLY, `LTM_CODE_GND, 3'h1},
    '{4'h3, `LTM_IDX_OV_LVL, 16'h000A, `LTM_IDX_VOLT_DLY, VCODE, 3'h2},
    '{4'h4, `LTM_IDX_UV_LVL, 16'h000A, `LTM_IDX_VOLT_DLY, VCODE, 3'h2},
    '{4'h5, `LTM_IDX_PLOSS_DLY, 16'h0002, `LTM_IDX_PLOSS_DLY, `LTM_CODE_PLOSS, 3'h3},
    '{4'h6, `LTM_IDX_OF_LVL, 16'h0048, `LTM_IDX_FREQ_DLY, `LTM_CODE_OF, 3'h4},
    '{4'h7, `LTM_IDX_UF_LVL, 16'h0017, `LTM_IDX_FREQ_DLY, `LTM_CODE_UF, 3'h5},
    '{4'h8, `LTM_IDX_LEAD_LVL, 16'h0101, `LTM_IDX_PF_DLY, `LTM_CODE_LEAD, 3'h6},
    '{4'h9, `LTM_IDX_LAG_LVL, 16'h01FF, `LTM_IDX_PF_DLY, `LTM_CODE_LAG, 3'h7}};
  localparam logic [15:0] RST [19] = '{16'h0000, `LTM_RST_IMB_LVL, `LTM_RST_IMB_DLY, 16'h0000, 16'h0000,
    `LTM_RST_GND_DLY, 16'h0000, 16'h0000, `LTM_RST_VOLT_DLY, `LTM_RST_PLOSS_DLY, `LTM_RST_OF_LVL,
    `LTM_RST_UF_LVL, `LTM_RST_FREQ_DLY, 16'h0000, 16'h0000, `LTM_RST_PF_DLY, `LTM_RST_RATED_V,
    `LTM_RST_FLA, 16'h0000};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  // page bits above the register window, nonzero only to reach unmapped space
  logic [24:0] hi_bits = 25'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic trip;
  logic [7:0] fault_code;
  logic volt_alarm;
  logic gnd_relay;
  logic [7:0] alarm;
  ltm_meas_t want;
  ltm_meas_t meas;
  int error_cnt = 0;
  int n_checks = 0;
  ltm_trip_monitor #(.TICK_CYCLES(10), .VOLT_FAULT_CODE(VCODE)) ltm_trip_monitor_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .meas(meas),
    .trip(trip), .fault_code(fault_code), .volt_alarm(volt_alarm), .gnd_relay(gnd_relay), .alarm(alarm));
  ltm_meas_model ltm_meas_model_inst (.hclk(hclk), .hresetn(hresetn), .want(want), .meas(meas));
  initial begin
    forever #5 hclk = ~hclk;
  end
  function automatic ltm_meas_t mk(input logic [3:0] k);
    ltm_meas_t m;
    m = '0;
    m.cur_a = 16'h0064;
    m.cur_b = 16'h0064;
    m.cur_c = 16'h0064;
    m.volt_a = 16'h01E0;
    m.volt_b = 16'h01E0;
    m.volt_c = 16'h01E0;
    m.freq_hz = 8'h3C;
    m.phase_ok = 1'b1;
    m.running = 1'b1;
    case (k)
      4'h0: begin
        m.cur_a = 16'h0082;
        m.cur_b = 16'h0055;
        m.cur_c = 16'h0055;
      end
      4'h1: m.inst_a = 16'h0014;
      4'h2: m.zs_gnd = 16'h000A;
      4'h3: m.volt_a = 16'h0258;
      4'h4: m.volt_a = 16'h012C;
      4'h5: m.phase_ok = 1'b0;
      4'h6: m.freq_hz = 8'h50;
      4'h7: m.freq_hz = 8'h14;
      4'h8: m.pf = 8'h14;
      4'h9: m.pf = 8'hEC;
      default: ;
    endcase
    return m;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {hi_bits, idx, 2'b00};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, {16'h0, d}, x);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    logic [31:0] rd;
    ltm_meas_t tmp;
    int w;
    want = mk(4'hF);
    @(posedge hclk);
    #1;
    chk({hready, hresp, trip, fault_code, alarm}, {3'b100, 16'h0});
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 19; i++) begin
      xfer(1'b0, i[4:0], 32'h0, rd);
      chk(rd, {16'h0, RST[i]});
    end
    // upper address bits set: neither stored nor read back
    hi_bits = 25'h1;
    xfer(1'b1, `LTM_IDX_IMB_LVL, 32'h0000_0033, rd);
    xfer(1'b0, `LTM_IDX_IMB_LVL, 32'h0, rd);
    chk(rd, 32'h0);
    hi_bits = 25'h0;
    xfer(1'b0, `LTM_IDX_IMB_LVL, 32'h0, rd);
    chk(rd, {16'h0, `LTM_RST_IMB_LVL});
    for (int r = 0; r < 10; r++) begin
      wr(ROWS[r].lidx, ROWS[r].lval);
      wr(ROWS[r].didx, 16'h0002);
      want <= mk(ROWS[r].kind);
      repeat (14) @(posedge hclk);
      chk(alarm[ROWS[r].abit], 1'b1);
      chk(trip, 1'b0);
      chk(gnd_relay, ROWS[r].abit == 3'h1);
      chk(volt_alarm, ROWS[r].abit == 3'h2);
      w = 0;
      while (trip !== 1'b1 && w < 60) begin
        @(posedge hclk);
        w++;
      end
      chk(fault_code, ROWS[r].code);
      xfer(1'b0, `LTM_IDX_STATUS, 32'h0, rd);
      chk(rd[8:0], {1'b1, ROWS[r].code});
      want <= mk(4'hF);
      repeat (10) @(posedge hclk);
      wr(`LTM_IDX_CTRL, 16'h0001);
      #1;
      chk({trip, fault_code}, 9'h0);
    end
    // condition broken off short of the delay twice must not add up
    want <= mk(4'h0);
    repeat (14) @(posedge hclk);
    want <= mk(4'hF);
    repeat (8) @(posedge hclk);
    want <= mk(4'h0);
    repeat (14) @(posedge hclk);
    chk(trip, 1'b0);
    want <= mk(4'hF);
    wr(`LTM_IDX_RES_LVL, 16'h0000);
    wr(`LTM_IDX_ZS_LVL, 16'h0000);
    wr(`LTM_IDX_IMB_LVL, 16'h0000);
    tmp = mk(4'h2);
    tmp.inst_a = 16'h0050;
    tmp.cur_a = 16'h0082;
    tmp.cur_b = 16'h0055;
    tmp.cur_c = 16'h0055;
    want <= tmp;
    repeat (40) @(posedge hclk);
    chk({alarm[1:0], gnd_relay, trip}, 4'h0);
    tmp = mk(4'h3);
    tmp.running = 1'b0;
    want <= tmp;
    repeat (40) @(posedge hclk);
    chk({volt_alarm, alarm[2], trip}, 3'b000);
    // a ground condition that arrives while another fault is latched is never timed
    wr(`LTM_IDX_ZS_LVL, 16'h000A);
    tmp = mk(4'h5);
    want <= tmp;
    w = 0;
    while (trip !== 1'b1 && w < 60) begin
      @(posedge hclk);
      w++;
    end
    chk(fault_code, `LTM_CODE_PLOSS);
    tmp.zs_gnd = 16'h000A;
    want <= tmp;
    repeat (40) @(posedge hclk);
    chk({alarm[1], gnd_relay, fault_code}, {2'b01, `LTM_CODE_PLOSS});
    // reset in mid-run drops the latched fault and restores the settings
    hresetn <= 1'b0;
    want <= mk(4'hF);
    @(posedge hclk);
    #1;
    chk({trip, fault_code, gnd_relay, alarm}, 18'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `LTM_IDX_IMB_LVL, 32'h0, rd);
    chk(rd, {16'h0, `LTM_RST_IMB_LVL});
    xfer(1'b0, `LTM_IDX_ZS_LVL, 32'h0, rd);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
